// ---- latc_pkg.sv ----
/*
 * Constants, register map and types of the embedded_logic_analyzer trigger and capture block.
 * Assumes a single analyzer clock and one instance; build options are the localparams below.
 */
package latc_pkg;

   // Build-time shape
   localparam int NPORT       = 2;
   localparam int TW          = 8;
   localparam int MU_PER_PORT = 2;
   localparam int NMU         = NPORT * MU_PER_PORT;
   localparam int MUW         = 2;
   localparam int MAX_MU      = 16;
   localparam int MAX_PORTS   = 16;
   localparam int MAX_TW      = 256;
   localparam int MAX_SW      = 4096;
   localparam int CW          = 8;
   localparam int DEPTH       = 256;
   localparam int AW          = 8;
   localparam int DW          = 16;
   localparam int SW          = 16;
   localparam int BUSW        = 32;
   localparam int SEQ_SELW    = 4;
   localparam int SEQ_LEVELS  = 16;

   // Build-time options
   localparam logic             TRIG_OUT_EN = 1'b1;
   localparam logic             EDGE_FALL   = 1'b0;
   localparam logic             SHARED_MODE = 1'b1;
   localparam logic [NPORT-1:0] PORT_EXCL   = 2'h0;
   localparam logic [5:0]       PORT_TYPE   = 6'h1d;

   // Match types: bit 0 adds edges, bits 2:1 give basic, extended or range
   localparam logic [1:0] MT_BASIC = 2'h0;
   localparam logic [1:0] MT_EXT   = 2'h1;
   localparam logic [1:0] MT_RANGE = 2'h2;

   // Match functions
   localparam logic [2:0] OP_EQ  = 3'h0;
   localparam logic [2:0] OP_NE  = 3'h1;
   localparam logic [2:0] OP_GT  = 3'h2;
   localparam logic [2:0] OP_GE  = 3'h3;
   localparam logic [2:0] OP_LT  = 3'h4;
   localparam logic [2:0] OP_LE  = 3'h5;
   localparam logic [2:0] OP_IN  = 3'h6;
   localparam logic [2:0] OP_OUT = 3'h7;

   // Trigger output timing
   localparam int TRIG_LAT   = 10;
   localparam int COND_STAGE = 4;
   localparam int FIRE_PIPE  = TRIG_LAT - COND_STAGE - 1;

   // Register offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_SEL      = 8'h08;
   localparam logic [7:0] REG_LEN      = 8'h0c;
   localparam logic [7:0] REG_SEQ_LAST = 8'h10;
   localparam logic [7:0] REG_SEQ_LO   = 8'h14;
   localparam logic [7:0] REG_SEQ_HI   = 8'h18;
   localparam logic [7:0] REG_RADDR    = 8'h1c;
   localparam logic [7:0] REG_RDATA    = 8'h20;
   localparam logic [7:0] UNIT_BASE    = 8'h40;
   localparam logic [7:0] UNIT_STRIDE  = 8'h20;
   localparam logic [7:0] U_VAL        = 8'h00;
   localparam logic [7:0] U_CARE       = 8'h04;
   localparam logic [7:0] U_EDGE       = 8'h08;
   localparam logic [7:0] U_HIGH       = 8'h0c;
   localparam logic [7:0] U_OPC        = 8'h10;

   // Field positions
   localparam int B_ARM        = 0;
   localparam int B_UPLOAD     = 1;
   localparam int B_SHAPE      = 2;
   localparam int B_POL        = 3;
   localparam int B_TAND       = 4;
   localparam int B_QEN        = 5;
   localparam int B_QAND       = 6;
   localparam int B_SEQEN      = 7;
   localparam int SEL_QUAL_LSB = 16;
   localparam int OPC_TGT_LSB  = 8;
   localparam int ST_LEVEL_LSB = 4;
   localparam int ST_WCNT_LSB  = 16;

   // Length reset value and buffer depth
   localparam logic [AW:0] LEN_RST = 9'h000;
   localparam logic [AW:0] DEPTH_W = 9'h100;

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CAPTURE, ST_DONE} latc_state_e;

endpackage : latc_pkg

// ---- latc_top.sv ----
/*
 * Trigger and capture logic of the embedded_logic_analyzer: match units, event counters,
 * trigger condition, sequencer, storage qualification, sample buffer and trigger output.
 * Assumes monitored logic on the analyzer clock and a host control port on the same clock.
 */
// Overview of operation
// - Trigger output follows condition ten cycles later
// - Upload done or re-arm clears trigger output
// - Host selects output shape and polarity
// - Trigger output only when build option set
// - Build option picks rising or falling edge
// - Buffer depth fixed at build time
// - Qualification condition gates every stored sample
// - Trigger starts capture, qualification picks samples
// - Shared mode stores trigger bits, 4096 max
// - Ports stored by default unless excluded
// - Independent mode stores separate data input
// - Trigger port width from 1 to 256
// - Each port drives 1 to 16 units
// - At most 16 match units overall
// - Optional loadable event counter per unit
// - Port match type limits compare functions
// - Bit values 0,1,X plus edge codes
// - Up to 16 trigger ports
// - Cyclic sequencer through up to 16 levels
`timescale 1ns/1ps
module latc_top (
   // Clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   // Monitored logic
   input  wire logic [latc_pkg::NPORT*latc_pkg::TW-1:0] trig_in,
   input  wire logic [latc_pkg::DW-1:0]               data_in,
   output logic                                       trig_out,
   // Host control port
   input  wire logic [7:0]                            addr,
   input  wire logic [latc_pkg::BUSW-1:0]             wdata,
   input  wire logic                                  wr,
   input  wire logic                                  rd,
   output logic [latc_pkg::BUSW-1:0]                  rdata
);

   localparam int TW  = latc_pkg::TW;
   localparam int NMU = latc_pkg::NMU;

   function automatic logic [7:0] unit_base(input int u);
      unit_base = 8'(latc_pkg::UNIT_BASE + u * latc_pkg::UNIT_STRIDE);
   endfunction : unit_base

   function automatic logic comb_cond(input logic and_mode, input logic [NMU-1:0] sel,
                                      input logic [NMU-1:0] ev);
      comb_cond = and_mode ? &(ev | ~sel) : |(ev & sel);
   endfunction : comb_cond

   function automatic logic unit_match(input logic [2:0] mtype, input logic [2:0] op,
                                       input logic [TW-1:0] x, input logic [TW-1:0] p,
                                       input logic [TW-1:0] v, input logic [TW-1:0] c,
                                       input logic [TW-1:0] e, input logic [TW-1:0] h);
      logic [TW-1:0] ok;
      logic [TW-1:0] ee;
      logic [TW-1:0] xm;
      logic [TW-1:0] vm;
      logic [TW-1:0] hm;
      logic          eq;
      logic [2:0]    eop;
      ee = mtype[0] ? e : '0;
      for (int b = 0; b < TW; b++) begin
         if (ee[b]) begin
            case ({c[b], v[b]})
               2'h0:    ok[b] = x[b] == p[b];
               2'h1:    ok[b] = !p[b] && x[b];
               2'h2:    ok[b] = p[b] && !x[b];
               default: ok[b] = x[b] != p[b];
            endcase
         end else begin
            ok[b] = !c[b] || (x[b] == v[b]);
         end
      end
      eq = &ok;
      xm = x & c & ~ee;
      vm = v & c & ~ee;
      hm = h & c & ~ee;
      eop = op;
      if (mtype[2:1] == latc_pkg::MT_BASIC && op > latc_pkg::OP_NE) eop = latc_pkg::OP_EQ;
      if (mtype[2:1] == latc_pkg::MT_EXT && op > latc_pkg::OP_LE) eop = latc_pkg::OP_EQ;
      case (eop)
         latc_pkg::OP_EQ: unit_match = eq;
         latc_pkg::OP_NE: unit_match = !eq;
         latc_pkg::OP_GT: unit_match = eq && (xm > vm);
         latc_pkg::OP_GE: unit_match = eq && (xm >= vm);
         latc_pkg::OP_LT: unit_match = eq && (xm < vm);
         latc_pkg::OP_LE: unit_match = eq && (xm <= vm);
         latc_pkg::OP_IN: unit_match = eq && (xm >= vm) && (xm <= hm);
         default:         unit_match = !((xm >= vm) && (xm <= hm));
      endcase
   endfunction : unit_match

   logic                                    aclk;
   logic                                    arm_p;
   logic                                    upload_p;
   logic                                    shape_q, pol_low_q, tand_q, qen_q, qand_q, seq_en_q;
   logic [NMU-1:0]                          tsel_q;
   logic [NMU-1:0]                          qsel_q;
   logic [latc_pkg::AW:0]                   len_q;
   logic [latc_pkg::AW:0]                   eff_len;
   logic [3:0]                              seq_last_q;
   logic [latc_pkg::SEQ_LEVELS*latc_pkg::SEQ_SELW-1:0] seq_sel_q;
   logic [latc_pkg::AW-1:0]                 raddr_q;
   logic [TW-1:0]                           val_q  [NMU];
   logic [TW-1:0]                           care_q [NMU];
   logic [TW-1:0]                           edge_q [NMU];
   logic [TW-1:0]                           high_q [NMU];
   logic [2:0]                              op_q   [NMU];
   logic [latc_pkg::CW-1:0]                 tgt_q  [NMU];
   logic [latc_pkg::CW-1:0]                 cnt_q  [NMU];
   logic [latc_pkg::NPORT*TW-1:0]           s1_q, prev_q;
   logic [latc_pkg::DW-1:0]                 ds1_q;
   logic [NMU-1:0]                          m_q, ev_q;
   logic [3:0]                              level_q;
   logic [latc_pkg::SEQ_SELW-1:0]           cur_sel;
   logic                                    seq_ev, cond, cond_q, qual_q, fire, wr_en;
   logic [latc_pkg::SW-1:0]                 word;
   logic [latc_pkg::SW-1:0]                 dp_q [3];
   logic [latc_pkg::SW-1:0]                 mem_q [latc_pkg::DEPTH];
   logic [latc_pkg::AW:0]                   wcnt_q;
   latc_pkg::latc_state_e                   st_q;
   logic [latc_pkg::FIRE_PIPE-1:0]          fp_q;
   logic                                    lat_q;
   logic [latc_pkg::BUSW-1:0]               rmux;

   // Inverting the clock moves the whole block, host port included, to the falling edge
   assign aclk = clk ^ latc_pkg::EDGE_FALL;

   assign arm_p    = wr && addr == latc_pkg::REG_CTRL && wdata[latc_pkg::B_ARM];
   assign upload_p = wr && addr == latc_pkg::REG_CTRL && wdata[latc_pkg::B_UPLOAD];

   // Control registers
   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         {shape_q, pol_low_q, tand_q, qen_q, qand_q, seq_en_q} <= 6'h00;
         tsel_q     <= '0;
         qsel_q     <= '0;
         len_q      <= latc_pkg::LEN_RST;
         seq_last_q <= 4'h0;
         seq_sel_q  <= '0;
      end else if (wr) begin
         if (addr == latc_pkg::REG_CTRL) begin
            shape_q   <= wdata[latc_pkg::B_SHAPE];
            pol_low_q <= wdata[latc_pkg::B_POL];
            tand_q    <= wdata[latc_pkg::B_TAND];
            qen_q     <= wdata[latc_pkg::B_QEN];
            qand_q    <= wdata[latc_pkg::B_QAND];
            seq_en_q  <= wdata[latc_pkg::B_SEQEN];
         end else if (addr == latc_pkg::REG_SEL) begin
            tsel_q <= wdata[NMU-1:0];
            qsel_q <= wdata[latc_pkg::SEL_QUAL_LSB +: NMU];
         end else if (addr == latc_pkg::REG_LEN) begin
            len_q <= wdata[latc_pkg::AW:0];
         end else if (addr == latc_pkg::REG_SEQ_LAST) begin
            seq_last_q <= wdata[3:0];
         end else if (addr == latc_pkg::REG_SEQ_LO) begin
            seq_sel_q[31:0] <= wdata;
         end else if (addr == latc_pkg::REG_SEQ_HI) begin
            seq_sel_q[63:32] <= wdata;
         end
      end
   end

   // Readout address steps after each buffer read
   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         raddr_q <= '0;
      end else if (wr && addr == latc_pkg::REG_RADDR) begin
         raddr_q <= wdata[latc_pkg::AW-1:0];
      end else if (rd && addr == latc_pkg::REG_RDATA) begin
         raddr_q <= raddr_q + 8'h01;
      end
   end

   // Inputs come from logic on this clock, so they are sampled once without a synchroniser
   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         s1_q   <= '0;
         prev_q <= '0;
         ds1_q  <= '0;
      end else begin
         s1_q   <= trig_in;
         prev_q <= s1_q;
         ds1_q  <= data_in;
      end
   end

   // Match units and their counters, MU_PER_PORT per port
   for (genvar u = 0; u < NMU; u++) begin : g_unit
      localparam int PORT = u / latc_pkg::MU_PER_PORT;
      localparam logic [2:0] MTYPE = latc_pkg::PORT_TYPE[PORT*3 +: 3];
      logic [7:0] base;
      assign base = unit_base(u);

      always_ff @(posedge aclk or negedge rstn) begin
         if (!rstn) begin
            val_q[u]  <= '0;
            care_q[u] <= '0;
            edge_q[u] <= '0;
            high_q[u] <= '0;
            op_q[u]   <= latc_pkg::OP_EQ;
            tgt_q[u]  <= '0;
         end else if (wr) begin
            if (addr == base + latc_pkg::U_VAL) begin
               val_q[u] <= wdata[TW-1:0];
            end else if (addr == base + latc_pkg::U_CARE) begin
               care_q[u] <= wdata[TW-1:0];
            end else if (addr == base + latc_pkg::U_EDGE) begin
               edge_q[u] <= wdata[TW-1:0];
            end else if (addr == base + latc_pkg::U_HIGH) begin
               high_q[u] <= wdata[TW-1:0];
            end else if (addr == base + latc_pkg::U_OPC) begin
               op_q[u]  <= wdata[2:0];
               tgt_q[u] <= wdata[latc_pkg::OPC_TGT_LSB +: latc_pkg::CW];
            end
         end
      end

      always_ff @(posedge aclk or negedge rstn) begin
         if (!rstn) begin
            m_q[u] <= 1'b0;
         end else begin
            m_q[u] <= unit_match(MTYPE, op_q[u], s1_q[PORT*TW +: TW], prev_q[PORT*TW +: TW],
                                 val_q[u], care_q[u], edge_q[u], high_q[u]);
         end
      end

      // A zero target passes every match through, so the counter costs nothing when unused
      always_ff @(posedge aclk or negedge rstn) begin
         if (!rstn) begin
            cnt_q[u] <= '0;
            ev_q[u]  <= 1'b0;
         end else begin
            ev_q[u] <= m_q[u] && (tgt_q[u] == '0 || cnt_q[u] + latc_pkg::CW'(1) == tgt_q[u]);
            if (arm_p) begin
               cnt_q[u] <= '0;
            end else if (m_q[u] && tgt_q[u] != '0) begin
               cnt_q[u] <= (cnt_q[u] + latc_pkg::CW'(1) == tgt_q[u]) ? '0 : cnt_q[u] + latc_pkg::CW'(1);
            end
         end
      end
   end

   // Sequencer: one level per selected unit event, wraps after the last level
   assign cur_sel = seq_sel_q[level_q*latc_pkg::SEQ_SELW +: latc_pkg::SEQ_SELW];
   assign seq_ev  = (cur_sel < latc_pkg::SEQ_SELW'(NMU)) && ev_q[cur_sel[latc_pkg::MUW-1:0]];
   assign cond    = seq_en_q ? (seq_ev && level_q == seq_last_q) : comb_cond(tand_q, tsel_q, ev_q);

   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         level_q <= 4'h0;
      end else if (arm_p) begin
         level_q <= 4'h0;
      end else if (seq_en_q && st_q == latc_pkg::ST_ARMED && seq_ev) begin
         level_q <= (level_q == seq_last_q) ? 4'h0 : level_q + 4'h1;
      end
   end

   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         cond_q <= 1'b0;
         qual_q <= 1'b0;
      end else begin
         cond_q <= cond;
         qual_q <= !qen_q || comb_cond(qand_q, qsel_q, ev_q);
      end
   end

   // Sample word, packed from included ports or taken from the data input
   always_comb begin
      int pos;
      pos  = 0;
      word = '0;
      if (latc_pkg::SHARED_MODE) begin
         for (int p = 0; p < latc_pkg::NPORT; p++) begin
            if (!latc_pkg::PORT_EXCL[p]) begin
               word = word | (latc_pkg::SW'(s1_q[p*TW +: TW]) << pos);
               pos  = pos + TW;
            end
         end
      end else begin
         word = ds1_q;
      end
   end

   // Delay the word so it meets its own qualification and trigger result
   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 3; i++) dp_q[i] <= '0;
      end else begin
         dp_q[0] <= word;
         dp_q[1] <= dp_q[0];
         dp_q[2] <= dp_q[1];
      end
   end

   // Capture control
   assign eff_len = (len_q == '0 || len_q > latc_pkg::DEPTH_W) ? latc_pkg::DEPTH_W : len_q;
   assign fire    = st_q == latc_pkg::ST_ARMED && cond_q;
   assign wr_en   = (fire || st_q == latc_pkg::ST_CAPTURE) && qual_q;

   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         st_q   <= latc_pkg::ST_IDLE;
         wcnt_q <= '0;
      end else if (arm_p) begin
         st_q   <= latc_pkg::ST_ARMED;
         wcnt_q <= '0;
      end else if (wr_en) begin
         wcnt_q <= wcnt_q + 9'h001;
         st_q   <= (wcnt_q + 9'h001 == eff_len) ? latc_pkg::ST_DONE : latc_pkg::ST_CAPTURE;
      end else if (fire) begin
         st_q <= latc_pkg::ST_CAPTURE;
      end
   end

   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem_q[wcnt_q[latc_pkg::AW-1:0]] <= dp_q[2];
      end
   end

   // Trigger output: fire pipe, level latch, shape and polarity
   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         fp_q <= '0;
      end else if (arm_p) begin
         fp_q <= '0;
      end else begin
         fp_q <= {fp_q[latc_pkg::FIRE_PIPE-2:0], fire};
      end
   end

   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         lat_q <= 1'b0;
      end else if (fp_q[latc_pkg::FIRE_PIPE-1]) begin
         lat_q <= 1'b1;
      end else if (arm_p || upload_p) begin
         lat_q <= 1'b0;
      end
   end

   // Without the build option the pin stays at constant low
   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         trig_out <= 1'b0;
      end else if (!latc_pkg::TRIG_OUT_EN) begin
         trig_out <= 1'b0;
      end else begin
         trig_out <= (shape_q ? fp_q[latc_pkg::FIRE_PIPE-1] : (lat_q || fp_q[latc_pkg::FIRE_PIPE-1]))
                     ^ pol_low_q;
      end
   end

   // Host read mux
   always_comb begin
      rmux = '0;
      if (addr == latc_pkg::REG_CTRL) begin
         rmux[7:2] = {seq_en_q, qand_q, qen_q, tand_q, pol_low_q, shape_q};
      end else if (addr == latc_pkg::REG_STATUS) begin
         rmux[0] = st_q == latc_pkg::ST_ARMED;
         rmux[1] = st_q == latc_pkg::ST_CAPTURE || st_q == latc_pkg::ST_DONE;
         rmux[2] = st_q == latc_pkg::ST_DONE;
         rmux[latc_pkg::ST_LEVEL_LSB +: 4] = level_q;
         rmux[latc_pkg::ST_WCNT_LSB +: latc_pkg::AW+1] = wcnt_q;
      end else if (addr == latc_pkg::REG_SEL) begin
         rmux[NMU-1:0] = tsel_q;
         rmux[latc_pkg::SEL_QUAL_LSB +: NMU] = qsel_q;
      end else if (addr == latc_pkg::REG_LEN) begin
         rmux[latc_pkg::AW:0] = len_q;
      end else if (addr == latc_pkg::REG_SEQ_LAST) begin
         rmux[3:0] = seq_last_q;
      end else if (addr == latc_pkg::REG_SEQ_LO) begin
         rmux = seq_sel_q[31:0];
      end else if (addr == latc_pkg::REG_SEQ_HI) begin
         rmux = seq_sel_q[63:32];
      end else if (addr == latc_pkg::REG_RADDR) begin
         rmux[latc_pkg::AW-1:0] = raddr_q;
      end else if (addr == latc_pkg::REG_RDATA) begin
         rmux[latc_pkg::SW-1:0] = mem_q[raddr_q];
      end else begin
         for (int u = 0; u < NMU; u++) begin
            if (addr == unit_base(u) + latc_pkg::U_VAL) begin
               rmux[TW-1:0] = val_q[u];
            end else if (addr == unit_base(u) + latc_pkg::U_CARE) begin
               rmux[TW-1:0] = care_q[u];
            end else if (addr == unit_base(u) + latc_pkg::U_EDGE) begin
               rmux[TW-1:0] = edge_q[u];
            end else if (addr == unit_base(u) + latc_pkg::U_HIGH) begin
               rmux[TW-1:0] = high_q[u];
            end else if (addr == unit_base(u) + latc_pkg::U_OPC) begin
               rmux[2:0] = op_q[u];
               rmux[latc_pkg::OPC_TGT_LSB +: latc_pkg::CW] = tgt_q[u];
            end
         end
      end
   end

   always_ff @(posedge aclk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else begin
         rdata <= rd ? rmux : '0;
      end
   end

endmodule : latc_top

// ---- latc_monitor.sv ----
/* Checker on the ports of latc_top: host port answers and trigger output shape.
   Assumes one analyzer clock, rstn active low, and no second CTRL write within two cycles of an arm. */
`timescale 1ns/1ps
module latc_monitor (
   // Clock and reset
   input wire logic                                    clk,
   input wire logic                                    rstn,
   // Monitored logic
   input wire logic [latc_pkg::NPORT*latc_pkg::TW-1:0] trig_in,
   input wire logic [latc_pkg::DW-1:0]                 data_in,
   input wire logic                                    trig_out,
   // Host port
   input wire logic [7:0]                              addr,
   input wire logic [latc_pkg::BUSW-1:0]               wdata,
   input wire logic                                    wr,
   input wire logic                                    rd,
   input wire logic [latc_pkg::BUSW-1:0]               rdata
);
   logic       ctrl_wr, arm_wr, upl_wr, pol, shp;
   logic [7:2] ctrl_q;
   logic [1:0] cw_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   assign ctrl_wr = wr && addr == latc_pkg::REG_CTRL;
   assign arm_wr  = ctrl_wr && wdata[latc_pkg::B_ARM];
   assign upl_wr  = ctrl_wr && wdata[latc_pkg::B_UPLOAD];
   assign pol     = ctrl_q[latc_pkg::B_POL];
   assign shp     = ctrl_q[latc_pkg::B_SHAPE];
   // The output lags a polarity change by a cycle, so cw_q masks that window
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= '0;
         cw_q   <= '0;
      end else begin
         cw_q <= {cw_q[0], ctrl_wr};
         if (ctrl_wr) begin
            ctrl_q <= wdata[7:2];
         end
      end
   end
   chk_arm_clear: assert property (arm_wr |-> ##2 trig_out == pol)
      else $error("trigger output not cleared by arm");
   chk_upload_clear: assert property (upl_wr |-> ##2 trig_out == pol)
      else $error("trigger output not cleared by upload");
   chk_level_hold: assert property (!shp && cw_q == 2'h0 && $past(trig_out) != pol |-> trig_out != pol)
      else $error("level trigger output dropped");
   chk_pulse_once: assert property (shp && cw_q == 2'h0 && trig_out != pol |=> trig_out == pol)
      else $error("pulse trigger output longer than one cycle");
   chk_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
      else $error("read data outside the answer cycle");
   chk_ctrl_readback: assert property ($past(rd) && $past(addr) == latc_pkg::REG_CTRL |->
      rdata == {24'h0, ctrl_q, 2'h0})
      else $error("control readback wrong");
   chk_status_resv: assert property ($past(rd) && $past(addr) == latc_pkg::REG_STATUS |->
      rdata[31:25] == '0 && rdata[15:8] == '0 && !rdata[3] && (rdata[1] || !rdata[2]))
      else $error("status reserved bits or flags wrong");
   chk_count_cap: assert property ($past(rd) && $past(addr) == latc_pkg::REG_STATUS |->
      rdata[24:16] <= latc_pkg::DEPTH_W)
      else $error("sample count above buffer depth");
   cov_arm: cover property (arm_wr);
   cov_toggle: cover property ($changed(trig_out));
   cov_upload: cover property (upl_wr);
endmodule : latc_monitor

bind latc_top latc_monitor mon_u (.clk(clk), .rstn(rstn), .trig_in(trig_in), .data_in(data_in), .trig_out(trig_out),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

// ---- latc_src.sv ----
/* Model of the monitored logic feeding the analyzer.
   Assumes the bench hands it the next sample; data input unused in shared mode. */
`timescale 1ns/1ps
module latc_src (
   // Clock
   input wire logic                                    clk,
   // Next sample from the bench
   input wire logic [latc_pkg::NPORT*latc_pkg::TW-1:0] val,
   // To the analyzer
   output logic [latc_pkg::NPORT*latc_pkg::TW-1:0]     trig_in,
   output logic [latc_pkg::DW-1:0]                     data_in
);
   // Launched only from the analyzer clock edge, as real user logic would be
   always_ff @(posedge clk) begin
      trig_in <= val;
      data_in <= '0;
   end
endmodule : latc_src

// ---- test_logic_analyzer_trigger_capture.sv ----
/* Self-checking bench for latc_top: an equality capture and an edge capture with qualification.
   Assumes the package build options: shared mode, rising edge, trigger output present. */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module test_logic_analyzer_trigger_capture;
   localparam int NS = 80;
   localparam int TI = 20;
   logic                                    clk, rstn, wr, rd, trig_out, qual_on;
   logic [7:0]                              addr, qval;
   logic [latc_pkg::BUSW-1:0]               wdata, rdata, rv;
   logic [latc_pkg::NPORT*latc_pkg::TW-1:0] val, trig_in;
   logic [latc_pkg::DW-1:0]                 data_in;
   logic [15:0]                             samp [NS];
   logic [7:0]                              regs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h24};
   int                                      n_errors, checks_done, seed, first_act, n_act, j;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   latc_top dut_u (.clk(clk), .rstn(rstn), .trig_in(trig_in), .data_in(data_in), .trig_out(trig_out),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   latc_src src_u (.clk(clk), .val(val), .trig_in(trig_in), .data_in(data_in));

   task automatic complete_run;
      if (n_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask : reg_rd

   task automatic unit_set(input logic [7:0] u, input logic [7:0] v, input logic [7:0] c, input logic [7:0] e);
      logic [7:0] b;
      b = latc_pkg::UNIT_BASE + latc_pkg::UNIT_STRIDE * u;
      reg_wr(b + latc_pkg::U_VAL, {24'h0, v});
      reg_wr(b + latc_pkg::U_CARE, {24'h0, c});
      reg_wr(b + latc_pkg::U_EDGE, {24'h0, e});
      reg_wr(b + latc_pkg::U_OPC, {29'h0, latc_pkg::OP_EQ});
   endtask : unit_set

   // Index of the next sample the qualification lets into the buffer
   function automatic int next_kept(input int k);
      while (k < NS - 1 && qual_on && samp[k][15:8] !== qval) k++;
      return k;
   endfunction : next_kept

   task automatic run_capture(input logic edge_run);
      int k;
      qval = 8'($random(seed)) | 8'h01;
      qual_on = edge_run;
      for (k = 0; k < NS; k++) begin
         samp[k] = 16'($random(seed));
         if (edge_run && k <= TI) samp[k][0] = (k == TI);
         if (!edge_run && k < TI && samp[k][7:0] == qval) samp[k][0] = ~samp[k][0];
         if (edge_run && k % 3 == 0) samp[k][15:8] = qval;
      end
      if (!edge_run) samp[TI][7:0] = qval;
      val <= '0;
      unit_set(8'h0, edge_run ? 8'h01 : qval, edge_run ? 8'h00 : 8'hff, {7'h0, edge_run});
      unit_set(8'h2, qval, 8'hff, 8'h00);
      reg_wr(latc_pkg::REG_LEN, 32'h8);
      reg_wr(latc_pkg::REG_SEL, edge_run ? 32'h0004_0001 : 32'h1);
      reg_wr(latc_pkg::REG_CTRL, edge_run ? 32'h2d : 32'h1);
      // The two-cycle readback also lets the new polarity reach the output
      reg_rd(latc_pkg::REG_CTRL, rv);
      `CHK(rv, edge_run ? 32'h2c : 32'h0)
      first_act = -1;
      n_act = 0;
      for (k = 0; k < NS; k++) begin
         @(posedge clk);
         val <= samp[k];
         #1;
         if (trig_out === ~edge_run) begin
            n_act++;
            if (first_act < 0) first_act = k;
         end
      end
      `CHK(first_act, TI + 11)
      `CHK(n_act, edge_run ? 1 : NS - TI - 11)
      for (j = 0; j < 20; j++) begin
         reg_rd(latc_pkg::REG_STATUS, rv);
         if (rv[2] === 1'b1) break;
      end
      if (j == 20) begin
         n_errors++;
         complete_run();
      end
      `CHK({rv[24:16], rv[2:0]}, {9'h8, 3'h6})
      reg_wr(latc_pkg::REG_RADDR, 32'h0);
      k = TI;
      for (int i = 0; i < 8; i++) begin
         k = next_kept(k);
         reg_rd(latc_pkg::REG_RDATA, rv);
         `CHK(rv, {16'h0, samp[k]})
         k++;
      end
      reg_wr(latc_pkg::REG_CTRL, edge_run ? 32'h2e : 32'h2);
      repeat (3) @(posedge clk);
   endtask : run_capture

   initial begin
      {rstn, wr, rd} = 3'h0;
      addr = '0;
      wdata = '0;
      val = '0;
      seed = 61451;
      n_errors = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      foreach (regs[i]) begin
         reg_rd(regs[i], rv);
         `CHK(rv, 32'h0)
      end
      run_capture(1'b0);
      run_capture(1'b1);
      complete_run();
   end
endmodule : test_logic_analyzer_trigger_capture
